// ===== verilog/tcic_pkg.sv
/*
 * tcic_pkg: register offsets, field positions, reset values and sizes of the
 * timer counter with input capture.
 * Assumes a 32-bit APB with word-aligned registers; data sits in bits 15:0.
 */
package tcic_pkg;

    // register byte offsets
    localparam logic [7:0] TCIC_OFF_CAPA   = 8'h00;
    localparam logic [7:0] TCIC_OFF_CAPB   = 8'h04;
    localparam logic [7:0] TCIC_OFF_COUNT  = 8'h10;
    localparam logic [7:0] TCIC_OFF_CTRL1  = 8'h14;
    localparam logic [7:0] TCIC_OFF_CTRL2  = 8'h18;
    localparam logic [7:0] TCIC_OFF_STATUS = 8'h1C;

    // control one fields
    localparam int TCIC_CR1_EXT_CLK   = 15;
    localparam int TCIC_CR1_EXT_EDGE  = 14;
    localparam int TCIC_CR1_CAPB_EDGE = 2;
    localparam int TCIC_CR1_CAPA_EDGE = 1;

    // control two fields
    localparam int TCIC_CR2_CAPA_IE  = 15;
    localparam int TCIC_CR2_CAPB_IE  = 12;
    localparam int TCIC_CR2_OVF_IE   = 13;
    localparam int TCIC_CR2_PRE_LSB  = 0;
    localparam int TCIC_CR2_PRE_MSB  = 7;

    // status fields
    localparam int TCIC_SR_CAPA = 15;
    localparam int TCIC_SR_OVF  = 13;
    localparam int TCIC_SR_CAPB = 12;

    // reset and load values
    localparam logic [15:0] TCIC_COUNT_LOAD  = 16'hFFFC;
    localparam logic [15:0] TCIC_COUNT_RST   = 16'hFFFC;
    localparam logic [15:0] TCIC_REG_RST     = 16'h0000;
    localparam logic [7:0]  TCIC_PRE_RST     = 8'h00;
    localparam logic [15:0] TCIC_COUNT_MAX   = 16'hFFFF;

    // synchroniser depth
    localparam int TCIC_SYNC_STAGES = 2;

endpackage

// ===== verilog/tcic_edge_sync.sv
/*
 * tcic_edge_sync: two-flop synchroniser with selectable edge detector for
 * one asynchronous pin.
 * Assumes the pin is slower than a quarter of pclk so no edge is missed.
 */
`timescale 1ns/1ns
`default_nettype none

module tcic_edge_sync
    import tcic_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin and edge choice
    input  wire logic pin_in,
    input  wire logic rise_sel,
    // one-cycle pulse on the chosen edge
    output logic      edge_pulse
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // meta_r is read only by sync_r, guarding against metastability
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // edge choice: high selects rising, low selects falling
    assign edge_pulse = rise_sel ? (sync_r & ~last_r) : (~sync_r & last_r);

endmodule

`default_nettype wire

// ===== verilog/tcic_timer.sv
/*
 * tcic_timer: 16-bit up counter with prescaler or external count input,
 * overflow flag and two input capture channels, as an APB slave.
 * Assumes pins are asynchronous to pclk; APB master follows the standard.
 */
// The implementer's own choices: the APB slave port and the register offsets.
// Overview of operation
// - counter write loads FFFCh regardless of data
// - clock select bit picks internal or external
// - internal rate from eight-bit prescale field
// - prescaler divides pclk by value plus one
// - wrap from maximum to zero sets overflow
// - overflow irq when flag and enable set
// - status write bit13 zero clears overflow
// - writing one to flags leaves them unchanged
// - edge select picks active external edge
// - external counts synchronised to pclk rising edge
// - each channel latches counter on active edge
// - capture registers read-only to software
// - per-channel edge select in control one
// - capture sets flag and holds sampled value
// - capture irq when flag and enable set
// - status bit15 or bit12 zero clears capture
// - three sources ORed into one timer irq
`timescale 1ns/1ns
`default_nettype none

module tcic_timer
    import tcic_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // external pins
    input  wire logic        external_count_input,
    input  wire logic        capture_a_input,
    input  wire logic        capture_b_input,
    // interrupts
    output logic             capture_a_interrupt,
    output logic             capture_b_interrupt,
    output logic             overflow_interrupt,
    output logic             timer_irq
);

    // registers
    logic [15:0] count_value_reg_r;
    logic [15:0] capture_a_value_r;
    logic [15:0] capture_b_value_r;
    logic [15:0] control_reg_one_r;
    logic [15:0] control_reg_two_r;
    logic        overflow_flag_r;
    logic        capture_a_flag_r;
    logic        capture_b_flag_r;
    logic [7:0]  pre_cnt_r;
    logic [31:0] prdata_r;

    // control field views
    wire        external_clock_select      = control_reg_one_r[TCIC_CR1_EXT_CLK];
    wire        external_clock_edge_select = control_reg_one_r[TCIC_CR1_EXT_EDGE];
    wire        capture_a_edge_select      = control_reg_one_r[TCIC_CR1_CAPA_EDGE];
    wire        capture_b_edge_select      = control_reg_one_r[TCIC_CR1_CAPB_EDGE];
    wire        capture_a_irq_enable       = control_reg_two_r[TCIC_CR2_CAPA_IE];
    wire        capture_b_irq_enable       = control_reg_two_r[TCIC_CR2_CAPB_IE];
    wire        overflow_irq_enable        = control_reg_two_r[TCIC_CR2_OVF_IE];
    wire [7:0]  prescale_factor =
        control_reg_two_r[TCIC_CR2_PRE_MSB:TCIC_CR2_PRE_LSB];

    // apb decode; single-cycle access phase
    wire        acc        = psel & penable;
    wire        wr         = acc & pwrite;
    wire        rd         = acc & ~pwrite;
    wire        hit_capa   = (paddr == TCIC_OFF_CAPA);
    wire        hit_capb   = (paddr == TCIC_OFF_CAPB);
    wire        hit_count  = (paddr == TCIC_OFF_COUNT);
    wire        hit_ctrl1  = (paddr == TCIC_OFF_CTRL1);
    wire        hit_ctrl2  = (paddr == TCIC_OFF_CTRL2);
    wire        hit_status = (paddr == TCIC_OFF_STATUS);
    wire        mapped     = hit_capa | hit_capb | hit_count
                           | hit_ctrl1 | hit_ctrl2 | hit_status;
    wire        wr_count   = wr & hit_count;
    wire        wr_status  = wr & hit_status;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // pin synchronisers and edge detectors
    logic ext_edge;
    logic capa_edge;
    logic capb_edge;

    tcic_edge_sync u_sync_ext (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (external_count_input),
        .rise_sel   (external_clock_edge_select),
        .edge_pulse (ext_edge)
    );

    tcic_edge_sync u_sync_capa (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (capture_a_input),
        .rise_sel   (capture_a_edge_select),
        .edge_pulse (capa_edge)
    );

    tcic_edge_sync u_sync_capb (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (capture_b_input),
        .rise_sel   (capture_b_edge_select),
        .edge_pulse (capb_edge)
    );

    // count enable: prescaler terminal or synchronised external edge
    wire pre_done  = (pre_cnt_r == prescale_factor);
    wire count_en  = external_clock_select ? ext_edge : pre_done;
    wire count_top = (count_value_reg_r == TCIC_COUNT_MAX);
    // a load in the same cycle cancels the roll-over, so no false flag
    wire wrap      = count_en & count_top & ~wr_count;

    // prescaler next value: counts 0..factor, so divides by factor plus one
    wire       pre_restart = pre_done | wr_count;
    wire [7:0] pre_cnt_nxt = pre_restart ? TCIC_PRE_RST : pre_cnt_r + 8'h01;

    // prescaler register; a counter write also restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r <= TCIC_PRE_RST;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // counter next value; a software write wins over a count in that cycle
    wire [15:0] count_inc           = count_value_reg_r + 16'h0001;
    wire [15:0] count_value_reg_nxt = wr_count ? TCIC_COUNT_LOAD :
                                      count_en ? count_inc : count_value_reg_r;

    // main counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg_r <= TCIC_COUNT_RST;
        end else begin
            count_value_reg_r <= count_value_reg_nxt;
        end
    end

    // capture next values; hardware only, the bus has no write path
    wire [15:0] capture_a_value_nxt =
        capa_edge ? count_value_reg_r : capture_a_value_r;
    wire [15:0] capture_b_value_nxt =
        capb_edge ? count_value_reg_r : capture_b_value_r;

    // capture a register; read-only to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_a_value_r <= TCIC_REG_RST;
        end else begin
            capture_a_value_r <= capture_a_value_nxt;
        end
    end

    // capture b register; read-only to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_b_value_r <= TCIC_REG_RST;
        end else begin
            capture_b_value_r <= capture_b_value_nxt;
        end
    end

    // control write strobes and next values; upper bus half ignored
    wire        wr_ctrl1            = wr & hit_ctrl1;
    wire        wr_ctrl2            = wr & hit_ctrl2;
    wire [15:0] control_reg_one_nxt = wr_ctrl1 ? pwdata[15:0] : control_reg_one_r;
    wire [15:0] control_reg_two_nxt = wr_ctrl2 ? pwdata[15:0] : control_reg_two_r;

    // control one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg_one_r <= TCIC_REG_RST;
        end else begin
            control_reg_one_r <= control_reg_one_nxt;
        end
    end

    // control two register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg_two_r <= TCIC_REG_RST;
        end else begin
            control_reg_two_r <= control_reg_two_nxt;
        end
    end

    // status clears: a zero clears, a one keeps
    wire clr_ovf  = wr_status & ~pwdata[TCIC_SR_OVF];
    wire clr_capa = wr_status & ~pwdata[TCIC_SR_CAPA];
    wire clr_capb = wr_status & ~pwdata[TCIC_SR_CAPB];

    // sticky flag next values; a set in the clear cycle wins so no event is lost
    wire overflow_flag_nxt  = wrap      | (overflow_flag_r  & ~clr_ovf);
    wire capture_a_flag_nxt = capa_edge | (capture_a_flag_r & ~clr_capa);
    wire capture_b_flag_nxt = capb_edge | (capture_b_flag_r & ~clr_capb);

    // overflow flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_r <= 1'b0;
        end else begin
            overflow_flag_r <= overflow_flag_nxt;
        end
    end

    // capture a flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_a_flag_r <= 1'b0;
        end else begin
            capture_a_flag_r <= capture_a_flag_nxt;
        end
    end

    // capture b flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_b_flag_r <= 1'b0;
        end else begin
            capture_b_flag_r <= capture_b_flag_nxt;
        end
    end

    // status read image
    wire [15:0] status_reg = (16'h0001 << TCIC_SR_CAPA) & {16{capture_a_flag_r}}
                           | (16'h0001 << TCIC_SR_OVF)  & {16{overflow_flag_r}}
                           | (16'h0001 << TCIC_SR_CAPB) & {16{capture_b_flag_r}};

    // read mux; unmapped reads return zero
    wire [15:0] rd_mux = hit_capa   ? capture_a_value_r :
                         hit_capb   ? capture_b_value_r :
                         hit_count  ? count_value_reg_r :
                         hit_ctrl1  ? control_reg_one_r :
                         hit_ctrl2  ? control_reg_two_r :
                         hit_status ? status_reg        : 16'h0000;

    // read data taken at the end of the setup cycle, so it stands at the access edge
    wire        rd_setup   = psel & ~penable & ~pwrite;
    wire [31:0] prdata_nxt = rd_setup ? {16'h0000, rd_mux} : prdata_r;

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // interrupt lines: pending flag gated by its enable
    assign overflow_interrupt  = overflow_flag_r  & overflow_irq_enable;
    assign capture_a_interrupt = capture_a_flag_r & capture_a_irq_enable;
    assign capture_b_interrupt = capture_b_flag_r & capture_b_irq_enable;

    // global line; compare sources live in the compare unit, absent here
    assign timer_irq = overflow_interrupt | capture_a_interrupt
                     | capture_b_interrupt;

    // external edges closer than one pclk may be merged by the detector

endmodule

`default_nettype wire

// ===== dv/tcic_timer_properties.sv
/* tcic_timer_properties: bus and interrupt checks on the timer's ports.
   Bound into every tcic_timer; needs tcic_pkg compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tcic_timer_properties
    import tcic_pkg::*;
(
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // interrupt outputs
    input wire logic        capture_a_interrupt,
    input wire logic        capture_b_interrupt,
    input wire logic        overflow_interrupt,
    input wire logic        timer_irq
);
    // decode; 08h and 0Ch are holes, status and enable bits share positions
    wire logic acc     = psel & penable;
    wire logic mapped  = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (paddr[4:3] != 2'h1);
    wire logic wr_ic   = acc & pwrite & (paddr == TCIC_OFF_STATUS || paddr == TCIC_OFF_CTRL2);
    wire logic clr_ovf = wr_ic & ~pwdata[TCIC_SR_OVF];
    wire logic clr_a   = wr_ic & ~pwdata[TCIC_SR_CAPA];
    wire logic clr_b   = wr_ic & ~pwdata[TCIC_SR_CAPB];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_slverr_on_hole: assert property (acc && !mapped |-> pslverr)
        else $error("no error response on unmapped access");
    a_slverr_quiet: assert property (!(acc && !mapped) |-> !pslverr)
        else $error("error response without cause");
    a_rdata_upper_zero: assert property (prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read setup");
    a_irq_or_sources: assert property (
        timer_irq == (capture_a_interrupt | capture_b_interrupt | overflow_interrupt))
        else $error("global interrupt differs from its sources");
    a_ovf_clear_cause: assert property ($fell(overflow_interrupt) |-> $past(clr_ovf))
        else $error("overflow interrupt fell without a clear");
    a_capa_clear_cause: assert property ($fell(capture_a_interrupt) |-> $past(clr_a))
        else $error("capture a interrupt fell without a clear");
    a_capb_clear_cause: assert property ($fell(capture_b_interrupt) |-> $past(clr_b))
        else $error("capture b interrupt fell without a clear");
endmodule
bind tcic_timer tcic_timer_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .capture_a_interrupt(capture_a_interrupt), .timer_irq(timer_irq),
    .capture_b_interrupt(capture_b_interrupt), .overflow_interrupt(overflow_interrupt));
`default_nettype wire

// ===== dv/tcic_pins_model.sv
/* tcic_pins_model: the far side, driving count and capture pins.
   Stepped by the bench; pins are plain levels with no pull. */
`timescale 1ns/1ns
`default_nettype none
module tcic_pins_model (
    // pacing clock
    input  wire logic pclk,
    // pins toward the timer
    output logic      ext_cnt,
    output logic      cap_a,
    output logic      cap_b
);
    // idle levels from time zero
    initial {ext_cnt, cap_a, cap_b} = 3'b000;
    // flip chosen pins, then rest eight edges: keeps count edges well apart
    task automatic flip(input logic [2:0] m);
        @(posedge pclk);
        {ext_cnt, cap_a, cap_b} <= {ext_cnt, cap_a, cap_b} ^ m;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_timer_counter_input_capture.sv
/* tb_timer_counter_input_capture: self-checking bench for tcic_timer.
   Assumes the pin model and the bound checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module tb_timer_counter_input_capture
    import tcic_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        ext_in, cap_a, cap_b, irq_a, irq_b, irq_ovf, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    int          num_errors, n_tests, p;
    // design and its pin partner
    tcic_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext_in), .capture_a_input(cap_a),
        .capture_b_input(cap_b), .capture_a_interrupt(irq_a), .capture_b_interrupt(irq_b),
        .overflow_interrupt(irq_ovf), .timer_irq(irq));
    tcic_pins_model u_pins (.pclk(pclk), .ext_cnt(ext_in), .cap_a(cap_a), .cap_b(cap_b));
    // xorshift stream, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // counter after n ticks from the load value
    function automatic logic [31:0] cnt_at(input int n);
        return {16'h0000, TCIC_COUNT_LOAD + 16'(n)};
    endfunction
    // counted comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; a read is compared with exp at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!w) check(rd, exp);
    endtask
    // verdict
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // watchdog well beyond the longest sequence
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        results();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h3AF5;
        num_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TCIC_OFF_CTRL2, 32'h0, 32'h0);
        apb(1'b0, 8'h08, 32'h0, 32'h0);
        check({31'h0, err}, 32'h1);
        p = 8 + int'(rnd() % 32'd248);
        apb(1'b1, TCIC_OFF_CTRL2, 32'(p), 32'h0);
        apb(1'b1, TCIC_OFF_COUNT, rnd(), 32'h0);
        apb(1'b0, TCIC_OFF_COUNT, 32'h0, cnt_at(0));
        repeat (3 * (p + 1)) @(posedge pclk);
        apb(1'b0, TCIC_OFF_COUNT, 32'h0, cnt_at(3));
        repeat (p + 1) @(posedge pclk);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h1 << TCIC_SR_OVF);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, TCIC_OFF_CTRL2, 32'(p) | (32'h1 << TCIC_CR2_OVF_IE), 32'h0);
        @(negedge pclk);
        check({30'h0, irq_ovf, irq}, 32'h3);
        apb(1'b1, TCIC_OFF_STATUS, 32'hFFFF, 32'h0);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h1 << TCIC_SR_OVF);
        apb(1'b1, TCIC_OFF_STATUS, ~(32'h1 << TCIC_SR_OVF), 32'h0);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h0);
        // falling then rising count edge; odd flip count tells them apart
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, TCIC_OFF_CTRL1, 32'h8000 | (32'(e) << TCIC_CR1_EXT_EDGE), 32'h0);
            apb(1'b1, TCIC_OFF_COUNT, rnd(), 32'h0);
            repeat (4 + e) u_pins.flip(3'b100);
            apb(1'b0, TCIC_OFF_COUNT, 32'h0, cnt_at(2 + e));
        end
        // external rising, capture a rising, capture b falling; one count edge between the captures
        apb(1'b1, TCIC_OFF_CTRL1, 32'hC002, 32'h0);
        apb(1'b1, TCIC_OFF_COUNT, rnd(), 32'h0);
        u_pins.flip(3'b010);
        repeat (2) u_pins.flip(3'b100);
        u_pins.flip(3'b001);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h1 << TCIC_SR_CAPA);
        u_pins.flip(3'b001);
        apb(1'b1, TCIC_OFF_CAPA, rnd(), 32'h0);
        apb(1'b0, TCIC_OFF_CAPA, 32'h0, cnt_at(0));
        apb(1'b0, TCIC_OFF_CAPB, 32'h0, cnt_at(1));
        apb(1'b1, TCIC_OFF_CTRL2, 32'h9000, 32'h0);
        @(negedge pclk);
        check({29'h0, irq_a, irq_b, irq}, 32'h7);
        apb(1'b1, TCIC_OFF_STATUS, ~(32'h1 << TCIC_SR_CAPA), 32'h0);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h1 << TCIC_SR_CAPB);
        apb(1'b1, TCIC_OFF_STATUS, ~(32'h1 << TCIC_SR_CAPB), 32'h0);
        apb(1'b0, TCIC_OFF_STATUS, 32'h0, 32'h0);
        results();
    end
endmodule
`default_nettype wire
